// File: spcc_defs.vh
`ifndef SPCC_DEFS_VH
`define SPCC_DEFS_VH

// ==========================================================
// register byte addresses
`define SPCC_ADDR_DIV1     32'h029c_0118
`define SPCC_ADDR_CMD      32'h029c_0138
`define SPCC_ADDR_STAT     32'h029c_013c
`define SPCC_ADDR_ALN      32'h029c_0140
`define SPCC_ADDR_DCHG     32'h029c_0144
`define SPCC_ADDR_DIVIDED_CLOCK_ON_STATUS   32'h029c_0150

// ==========================================================
// field positions
`define SPCC_DIV1_EN_BIT   15
`define SPCC_RATIO_MSB     4
`define SPCC_GO_BIT        0
`define SPCC_STAT_BIT      0
`define SPCC_ALN_BIT       0
`define SPCC_DCHG_BIT      0
`define SPCC_ON_BIT        0

// ==========================================================
// reset values and ratio codes
`define SPCC_RATIO_DIV2    5'h01
`define SPCC_RATIO_DIV5    5'h04
`define SPCC_RST_RATIO     5'h01
`define SPCC_RST_EN        1'b1
`define SPCC_RST_ALN       1'b1

// ==========================================================
// timing counts
`define SPCC_GO_CYCLES     8'h08

`endif

// File: spcc_half_div.v
`timescale 1ns/1ns
// ==========================================================
// divide-by-two toggle for the sdram and reference clock
module spcc_half_div (
  input  wire clk,
  input  wire rst,
  input  wire tick,
  output reg  clk_half
);
  // toggle on each tick of the sampled multiplier clock, no derived clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_half <= 1'b0;
    end else if (tick) begin
      clk_half <= ~clk_half;
    end
  end
endmodule // spcc_half_div

// File: spcc_ratio_div.v
`timescale 1ns/1ns
`include "spcc_defs.vh"
// ==========================================================
// programmable divider, runs on ticks of the reference clock
module spcc_ratio_div (
  input  wire       clk,
  input  wire       rst,
  input  wire       tick,
  input  wire       enable,
  input  wire       align,
  input  wire [4:0] ratio,
  output reg        div_out
);
  reg [4:0] count;

  // count 0..ratio, output high during the first half
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count   <= 5'h00;
      div_out <= 1'b0;
    end else if (!enable || align) begin
      count   <= 5'h00;
      div_out <= 1'b0;
    end else if (tick) begin
      if (count >= ratio) begin
        count <= 5'h00;
      end else begin
        count <= count + 5'h01;
      end
      div_out <= (count >= ratio) ? 1'b1 : (({count, 1'b0} + 6'h02) <= {1'b0, ratio});
    end
  end
endmodule // spcc_ratio_div

// File: spcc_controller.v
`timescale 1ns/1ns
`include "spcc_defs.vh"
// ==========================================================
// Behaviour
// - halve multiplier output clock and send it to sdram controller
// - halved clock returns as reference that drives output divider
// - output divider makes the mac media clock
// - mac bus clock is a separate third clock, not the media clock
// - only multiplied mode; reference is always the halved output
// - power-on and warm reset restore every register default
// - lock lost only during power-up, held before reset done rises; here every rst, warm reset too, clears pll_locked
// - registers reached only by processor or emulator accesses
// - reserved bits read zero, writes to them ignored
// - bit 15 of divider register enables the output divider
// - ratio bits 4:0, code 1h divide two, 4h divide five
// - writing one to go bit starts go; bit stays; zero clears it
// - status bit 0 reads one while go changes the ratio
// - writing a different ratio sets flag; go applies only if flagged
// - align bit one aligns and loads ratio; zero switches immediately
module spcc_controller #(
  parameter [7:0] GO_CYCLES = `SPCC_GO_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        multiplier_output_clock,
  input  wire        mac_bus_clock_in,
  input  wire        lock_in,
  input  wire        reg_cpu_sel,
  input  wire        reg_emu_sel,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_ack,
  output reg         sdram_clock_output,
  output reg         divider_reference_clock,
  output reg         mac_media_clock,
  output reg         mac_bus_clock,
  output reg         pll_locked
);

  // ==========================================================
  // state
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ALIGN = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  // programmer-visible state
  reg        divider_output_enable;
  reg  [4:0] ratio_field;
  reg        go_command_bit;
  reg        align_on_go_bit;
  reg        ratio_modified_flag;

  // go sequencer state
  reg  [4:0] active_ratio;
  reg        go_in_progress_flag;
  reg  [1:0] go_state;
  reg  [7:0] go_count;
  reg        align_pulse;

  // synchroniser and edge flops
  reg        lock_meta;
  reg        lock_sync;
  reg        bus_meta;
  reg        bus_sync;
  reg        mul_meta;
  reg        mul_sync;
  reg        mul_prev;
  reg        half_prev;

  // internal nets
  wire       half_clk;
  wire       div_clk;
  wire       mul_rise;
  wire       access;
  wire       wr_div;
  wire       wr_cmd;
  wire       wr_aln;
  wire       go_start;
  wire       go_done;
  wire       ref_tick;

  // ==========================================================
  // helper functions

  // exact match of a full byte address
  function spcc_hit;
    input [31:0] addr;
    input [31:0] base;
    begin
      spcc_hit = (addr == base);
    end
  endfunction

  // one flag in bit 0, reserved bits zero
  function [31:0] spcc_flag_word;
    input flag;
    begin
      spcc_flag_word = {31'h0000_0000, flag};
    end
  endfunction

  // divider word: enable, ratio, reserved bits zero
  function [31:0] spcc_div_word;
    input       en;
    input [4:0] ratio;
    begin
      spcc_div_word = {16'h0000, en, 10'h000, ratio};
    end
  endfunction

  // ==========================================================
  // address decode
  // only processor or emulator selects open the map
  assign access   = reg_cpu_sel | reg_emu_sel;
  assign wr_div   = access & reg_wr & spcc_hit(reg_addr, `SPCC_ADDR_DIV1);
  assign wr_cmd   = access & reg_wr & spcc_hit(reg_addr, `SPCC_ADDR_CMD);
  assign wr_aln   = access & reg_wr & spcc_hit(reg_addr, `SPCC_ADDR_ALN);
  assign go_start = wr_cmd & reg_wdata[`SPCC_GO_BIT];
  // last counted cycle of a go operation
  assign go_done  = (go_state == ST_RUN) && (go_count == 8'h00);

  // ==========================================================
  // pin synchronisers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      bus_meta  <= 1'b0;
      bus_sync  <= 1'b0;
      mul_meta  <= 1'b0;
      mul_sync  <= 1'b0;
      mul_prev  <= 1'b0;
    end else begin
      lock_meta <= lock_in;
      lock_sync <= lock_meta;
      bus_meta  <= mac_bus_clock_in;
      bus_sync  <= bus_meta;
      mul_meta  <= multiplier_output_clock;
      mul_sync  <= mul_meta;
      mul_prev  <= mul_sync;
    end
  end

  // rising edge of sampled multiplier clock
  assign mul_rise = mul_sync & ~mul_prev;

  // ==========================================================
  // halved clock; multiplied mode only, no bypass path
  spcc_half_div u_half (
    .clk      (clk),
    .rst      (rst),
    .tick     (mul_rise),
    .clk_half (half_clk)
  );

  // reference tick taken from the halved clock toggling high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      half_prev <= 1'b0;
    end else begin
      half_prev <= half_clk;
    end
  end
  assign ref_tick = half_clk & ~half_prev;

  // ==========================================================
  // output divider
  spcc_ratio_div u_div (
    .clk     (clk),
    .rst     (rst),
    .tick    (ref_tick),
    .enable  (divider_output_enable),
    .align   (align_pulse),
    .ratio   (active_ratio),
    .div_out (div_clk)
  );

  // ==========================================================
  // registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      divider_output_enable <= `SPCC_RST_EN;
      ratio_field           <= `SPCC_RST_RATIO;
      align_on_go_bit       <= `SPCC_RST_ALN;
      go_command_bit        <= 1'b0;
      ratio_modified_flag   <= 1'b0;
    end else begin
      if (wr_div) begin
        divider_output_enable <= reg_wdata[`SPCC_DIV1_EN_BIT];
        ratio_field           <= reg_wdata[`SPCC_RATIO_MSB:0];
      end
      if (wr_aln) begin
        align_on_go_bit <= reg_wdata[`SPCC_ALN_BIT];
      end
      if (wr_cmd) begin
        go_command_bit <= reg_wdata[`SPCC_GO_BIT];
      end
      // a new ratio write outranks the completion clear
      if (wr_div && reg_wdata[`SPCC_RATIO_MSB:0] != ratio_field) begin
        ratio_modified_flag <= 1'b1;
      end else if (go_done) begin
        ratio_modified_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // go sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      go_state            <= ST_IDLE;
      go_count            <= 8'h00;
      go_in_progress_flag <= 1'b0;
      active_ratio        <= `SPCC_RST_RATIO;
      align_pulse         <= 1'b0;
    end else begin
      align_pulse <= 1'b0;
      case (go_state)
        ST_IDLE: begin
          if (go_start) begin
            go_in_progress_flag <= 1'b1;
            go_count            <= GO_CYCLES;
            if (align_on_go_bit) begin
              go_state <= ST_ALIGN;
            end else begin
              if (ratio_modified_flag) begin
                active_ratio <= ratio_field;
              end
              go_state <= ST_RUN;
            end
          end
        end
        ST_ALIGN: begin
          align_pulse <= 1'b1;
          if (ratio_modified_flag) begin
            active_ratio <= ratio_field;
          end
          go_state <= ST_RUN;
        end
        ST_RUN: begin
          if (go_done) begin
            go_in_progress_flag <= 1'b0;
            go_state            <= ST_IDLE;
          end else begin
            go_count <= go_count - 8'h01;
          end
        end
        default: begin
          go_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // read path, one cycle answer, unmapped reads zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack   <= access & (reg_rd | reg_wr);
      reg_rdata <= 32'h0000_0000;
      if (access && reg_rd) begin
        case (reg_addr)
          `SPCC_ADDR_DIV1:   reg_rdata <= spcc_div_word(divider_output_enable, ratio_field);
          `SPCC_ADDR_CMD:    reg_rdata <= spcc_flag_word(go_command_bit);
          `SPCC_ADDR_STAT:   reg_rdata <= spcc_flag_word(go_in_progress_flag);
          `SPCC_ADDR_ALN:    reg_rdata <= spcc_flag_word(align_on_go_bit);
          `SPCC_ADDR_DCHG:   reg_rdata <= spcc_flag_word(ratio_modified_flag);
          `SPCC_ADDR_DIVIDED_CLOCK_ON_STATUS: reg_rdata <= spcc_flag_word(divider_output_enable);
          default:           reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // registered clock outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sdram_clock_output      <= 1'b0;
      divider_reference_clock <= 1'b0;
      mac_media_clock         <= 1'b0;
      mac_bus_clock           <= 1'b0;
      pll_locked              <= 1'b0;
    end else begin
      sdram_clock_output      <= half_clk;
      divider_reference_clock <= half_clk;
      mac_media_clock         <= div_clk;
      mac_bus_clock           <= bus_sync;
      pll_locked              <= lock_sync;
    end
  end
endmodule // spcc_controller

// File: spcc_src.sv
`timescale 1ns/1ns
// ==========================================================
// far-side clock sources
module spcc_src (
  output reg mult_clk,
  output reg bus_clk,
  output reg lock
);
  // lock gained once, only during power-up
  initial begin
    mult_clk = 1'b0;
    bus_clk = 1'b0;
    lock = 1'b0;
    #200 lock = 1'b1;
  end
  // multiplier output slow enough to sample
  always #80 mult_clk = ~mult_clk;
  // separate bus clock, edges kept off the sampling clock edges
  always #16 bus_clk = ~bus_clk;
endmodule // spcc_src

// File: spcc_controller_props.sv
`timescale 1ns/1ns
`include "spcc_defs.vh"
// ==========================================================
// port checker
module spcc_controller_props #(
  parameter [7:0] GO_CYCLES = `SPCC_GO_CYCLES
) (
  input wire        clk,
  input wire        rst,
  input wire        multiplier_output_clock,
  input wire        lock_in,
  input wire        reg_cpu_sel,
  input wire        reg_emu_sel,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        reg_ack,
  input wire        sdram_clock_output,
  input wire        divider_reference_clock,
  input wire        mac_media_clock,
  input wire        pll_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire sel = reg_cpu_sel | reg_emu_sel;
  // access steps
  sequence s_go_wr;
    sel && reg_wr && reg_addr == `SPCC_ADDR_CMD && reg_wdata[0];
  endsequence
  sequence s_stat_rd;
    sel && reg_rd && reg_addr == `SPCC_ADDR_STAT;
  endsequence
  sequence s_off_wr;
    sel && reg_wr && reg_addr == `SPCC_ADDR_DIV1 && !reg_wdata[15];
  endsequence
  a_access_acked:
    assert property (sel && (reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
  a_foreign_ignored:
    assert property (!sel |=> !reg_ack) else $error("ack without select");
  a_idle_rdata_zero:
    assert property (!reg_ack |-> reg_rdata == 32'h0000_0000) else $error("idle data");
  a_stat_reserved:
    assert property (s_stat_rd |=> reg_rdata[31:1] == 31'h0000_0000) else $error("stat bits");
  a_go_busy:
    assert property (s_go_wr ##[1:2] s_stat_rd |=> reg_rdata[0]) else $error("go not busy");
  a_ref_is_sdram:
    assert property (divider_reference_clock == sdram_clock_output) else $error("ref differs");
  a_half_quiet:
    assert property (!multiplier_output_clock [*6] |-> $stable(sdram_clock_output))
      else $error("half clock moved");
  a_lock_follows:
    assert property ($stable(lock_in) [*5] |-> pll_locked == lock_in) else $error("lock lag");
  a_off_no_clock:
    assert property (s_off_wr ##1 !(sel && reg_wr) [*4] |-> !mac_media_clock)
      else $error("clock while off");
endmodule // spcc_controller_props
bind spcc_controller spcc_controller_props #(.GO_CYCLES(GO_CYCLES)) u_props (.clk, .rst,
  .multiplier_output_clock, .lock_in, .reg_cpu_sel, .reg_emu_sel, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .sdram_clock_output,
  .divider_reference_clock, .mac_media_clock, .pll_locked);

// File: spcc_controller_tb.sv
`timescale 1ns/1ns
`include "spcc_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================
// bench top
module spcc_controller_tb;
  reg        clk, rst, cpu, emu, wr, rd;
  reg [31:0] addr, wdata, q;
  reg        pb;
  wire [31:0] rdata;
  wire       ack, sdr, ref_clk, media, bus, locked, mclk, bclk, lin;
  integer    err_total = 0, n_tests = 0, cyc = 0, np, nr, i;
  spcc_src src (.mult_clk(mclk), .bus_clk(bclk), .lock(lin));
  spcc_controller #(.GO_CYCLES(8'h08)) dut (.clk(clk), .rst(rst),
    .multiplier_output_clock(mclk), .mac_bus_clock_in(bclk), .lock_in(lin),
    .reg_cpu_sel(cpu), .reg_emu_sel(emu), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .sdram_clock_output(sdr),
    .divider_reference_clock(ref_clk), .mac_media_clock(media), .mac_bus_clock(bus),
    .pll_locked(locked));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  // one-cycle strobe, answer taken with ack
  task acc(input [1:0] s, input w, input [31:0] a, d);
    begin
      @(posedge clk);
      #1 {emu, cpu, wr, rd, addr, wdata} = {s, w, !w, a, d};
      @(posedge clk);
      #1 {emu, cpu, wr, rd} = 4'h0;
      q = rdata;
      if (s != 2'b00) `CHK(ack, 1'b1)
    end
  endtask
  task chk(input [31:0] a, e);
    begin
      acc(2'b01, 1'b0, a, 32'h0000_0000);
      `CHK(q, e)
    end
  endtask
  // cycles between rises of media (m) or reference clock
  task per(input m, output integer n);
    integer k;
    reg p;
    begin
      k = 0;
      n = 0;
      @(posedge clk);
      #1 p = m ? media : ref_clk;
      while (k < 2) begin
        @(posedge clk);
        #1 n++;
        if ((m ? media : ref_clk) && !p) begin
          k++;
          if (k == 1) n = 0;
        end
        p = m ? media : ref_clk;
      end
    end
  endtask
  task go(input integer r);
    begin
      chk(`SPCC_ADDR_STAT, 32'h0000_0000);
      acc(2'b10, 1'b1, `SPCC_ADDR_CMD, 32'hffff_ffff);
      chk(`SPCC_ADDR_STAT, 32'h0000_0001);
      chk(`SPCC_ADDR_CMD, 32'h0000_0001);
      repeat (30) @(posedge clk);
      chk(`SPCC_ADDR_STAT, 32'h0000_0000);
      chk(`SPCC_ADDR_DCHG, 32'h0000_0000);
      per(1'b0, nr);
      per(1'b1, np);
      per(1'b1, np);
      `CHK(np, r * nr)
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    {rst, emu, cpu, wr, rd, addr, wdata} = {5'h10, 64'h0};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk(`SPCC_ADDR_DIV1, 32'h0000_8001);
    chk(`SPCC_ADDR_ALN, 32'h0000_0001);
    chk(`SPCC_ADDR_DIVIDED_CLOCK_ON_STATUS, 32'h0000_0001);
    per(1'b0, nr);
    per(1'b1, np);
    `CHK(np, 2 * nr)
    pb = bus;
    i = 0;
    nr = 0;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (bus && !pb) i++;
      if (sdr !== ref_clk) nr++;
      pb = bus;
    end
    `CHK(i, 20)
    `CHK(nr, 0)
    $display("test defaults done");
    acc(2'b01, 1'b1, `SPCC_ADDR_DIV1, 32'hffff_ffe4);
    chk(`SPCC_ADDR_DIV1, 32'h0000_8004);
    chk(`SPCC_ADDR_DCHG, 32'h0000_0001);
    go(5);
    acc(2'b00, 1'b1, `SPCC_ADDR_DIV1, 32'h0000_8001);
    acc(2'b01, 1'b1, `SPCC_ADDR_DIV1, 32'h0000_8004);
    chk(`SPCC_ADDR_DCHG, 32'h0000_0000);
    acc(2'b01, 1'b1, `SPCC_ADDR_CMD, 32'h0000_0000);
    chk(`SPCC_ADDR_CMD, 32'h0000_0000);
    acc(2'b01, 1'b1, 32'h029c_0148, 32'hffff_ffff);
    chk(32'h029c_0148, 32'h0000_0000);
    go(5);
    $display("test go_flags done");
    acc(2'b01, 1'b1, `SPCC_ADDR_ALN, 32'hffff_fffe);
    chk(`SPCC_ADDR_ALN, 32'h0000_0000);
    acc(2'b01, 1'b1, `SPCC_ADDR_DIV1, 32'h0000_8001);
    go(2);
    acc(2'b01, 1'b1, `SPCC_ADDR_DIV1, 32'h0000_0001);
    chk(`SPCC_ADDR_DIVIDED_CLOCK_ON_STATUS, 32'h0000_0000);
    i = 0;
    repeat (100) begin
      @(posedge clk);
      #1 if (media !== 1'b0) i++;
    end
    `CHK(i, 0)
    $display("test align_off done");
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(`SPCC_ADDR_DIV1, 32'h0000_8001);
    chk(`SPCC_ADDR_ALN, 32'h0000_0001);
    `CHK(locked, 1'b1)
    $display("test warm_reset done");
    test_done;
  end
endmodule // spcc_controller_tb
